/* File: fsrc_ctrl.v */
// flash security, backdoor unlock and reset-sequence control
// Function
// - load security register from byte each reset
// - new security byte applies after reset only
// - backdoor key is four stored words
// - key-enable gates verify-key comparison of keys
// - match forces security state field to unsecure
// - all-zeros and all-ones keys never unlock
// - flash reads invalid while verify-key runs
// - illegal key blocks verify-key until reset
// - verify-key leaves stored bytes and protection
// - special mode erased-verify unsecures, enables debug
// - commands gated by mode and security
// - reset sequence loads config, protection, option, security
// - reset sequence error gives secured defaults
// - double fault in sequence sets verify bits
// - complete flag low during sequence, then high
// - stall accesses during initial hold
// - command register writes ignored until complete
// - reset aborts running command immediately
// - complete flag clear while command executes
// - stop request waits for active command
`timescale 1ns/1ns
`include "fsrc_defines.vh"
module fsrc_ctrl #(
  parameter [1:0] BACKDOOR_KEY_ENABLE_FIELD_ENABLED = 2'h2,
  parameter [3:0] HOLD_CYCLES = `FSRC_HOLD_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // nonvolatile read port used by the reset sequence
  output reg nv_rd_q,
  output reg [17:0] nv_addr_q,
  input wire nv_rd_valid,
  input wire [15:0] nv_rd_data,
  input wire nv_rd_error,
  input wire nv_double_fault,
  // mode and command interface from the cpu or debug port
  input wire special_mode,
  input wire cmd_launch,
  input wire cmd_is_verify_key,
  input wire cmd_is_erase_verify_all,
  input wire cmd_allowed_secure,
  input wire cmd_allowed_unsecure,
  input wire [63:0] cmd_keys,
  input wire engine_done,
  input wire engine_erased,
  input wire cmdreg_wr,
  input wire stop_req,
  // results
  output reg security_state_field_q,
  output reg [7:0] security_register_q,
  output reg [7:0] program_area_protection_register_q,
  output reg [7:0] data_area_protection_register_q,
  output reg [7:0] option_register_q,
  output reg [7:0] block_config_q,
  output reg [1:0] verify_status_bits_q,
  output reg command_complete_flag_q,
  output reg cpu_stall_q,
  output reg flash_read_invalid_q,
  output reg cmd_accepted_q,
  output reg cmd_rejected_q,
  output reg cmdreg_wr_en_q,
  output reg debug_enabled_q,
  output reg key_blocked_q,
  output reg stop_ack_q,
  output reg engine_start_q
);
  // ------------------------------------------------------------
  // state encoding
  // ------------------------------------------------------------
  localparam [2:0] ST_HOLD = 3'h0;
  localparam [2:0] ST_READ = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_IDLE = 3'h3;
  localparam [2:0] ST_BUSY = 3'h4;
  localparam [2:0] ST_KEY = 3'h5;

  reg [2:0] state_q;
  reg [3:0] hold_cnt_q;
  reg [2:0] item_q;
  reg key_cmd_q;
  reg erase_verify_q;
  reg [7:0] sec_work;
  wire seq_any_error;
  wire seq_double_fault;
  wire [3:0] key_ok;
  wire [3:0] key_illegal;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // address of each reset-sequence item in the configuration field
  function [17:0] item_addr;
    input [2:0] item;
    begin
      case (item)
        `FSRC_ITEM_SEC: item_addr = `FSRC_ADDR_SEC_BYTE;
        default: item_addr = `FSRC_ADDR_KEY_LAST + {15'h0, item} + 18'h1;
      endcase
    end
  endfunction

  // secured unless the field holds the unsecure code
  function is_unsecure;
    input [7:0] secreg;
    begin
      is_unsecure = (secreg[`FSRC_SEC_MSB:`FSRC_SEC_LSB] == `FSRC_SEC_UNSECURE);
    end
  endfunction

  // ------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------
  fsrc_ecc_status u_status (
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .clear(1'b0),
    .read_strobe(nv_rd_valid && state_q == ST_WAIT),
    .read_error(nv_rd_error),
    .double_fault(nv_double_fault),
    .any_error_q(seq_any_error),
    .double_fault_q(seq_double_fault)
  );

  // key words are taken from the stored copy, candidates from the command
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
      fsrc_key_check #(.WIDTH(16)) u_chk (
        .stored_word(nv_rd_data),
        .candidate_word(cmd_keys[gi*16 +: 16]),
        .word_ok(key_ok[gi]),
        .word_illegal(key_illegal[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // main sequencer
  // ------------------------------------------------------------
  // stored key words arrive one per read; candidates compared in turn
  reg key_bad_q;
  always @* begin
    sec_work = security_register_q;
    sec_work[`FSRC_SEC_MSB:`FSRC_SEC_LSB] = `FSRC_SEC_UNSECURE;
  end

  always @(posedge clk) begin
    if (!resetn) begin
      // reset aborts any command at once, engine start dropped
      state_q <= ST_HOLD;
      hold_cnt_q <= 4'h0;
      item_q <= 3'h0;
      key_cmd_q <= 1'b0;
      key_bad_q <= 1'b0;
      erase_verify_q <= 1'b0;
      nv_rd_q <= 1'b0;
      nv_addr_q <= 18'h0;
      security_state_field_q <= 1'b1;
      security_register_q <= `FSRC_DFLT_SECURITY;
      program_area_protection_register_q <= `FSRC_DFLT_PROT;
      data_area_protection_register_q <= `FSRC_DFLT_PROT;
      option_register_q <= `FSRC_DFLT_OPTION;
      block_config_q <= `FSRC_DFLT_CONFIG;
      verify_status_bits_q <= 2'h0;
      command_complete_flag_q <= 1'b0;
      cpu_stall_q <= 1'b1;
      flash_read_invalid_q <= 1'b0;
      cmd_accepted_q <= 1'b0;
      cmd_rejected_q <= 1'b0;
      cmdreg_wr_en_q <= 1'b0;
      debug_enabled_q <= 1'b0;
      key_blocked_q <= 1'b0;
      stop_ack_q <= 1'b0;
      engine_start_q <= 1'b0;
    end else if (clk_en) begin
      cmd_accepted_q <= 1'b0;
      cmd_rejected_q <= 1'b0;
      engine_start_q <= 1'b0;
      nv_rd_q <= 1'b0;
      // stop only granted when no command is active
      stop_ack_q <= stop_req && command_complete_flag_q;
      case (state_q)
        ST_HOLD: begin
          if (hold_cnt_q == HOLD_CYCLES - 4'h1) begin
            cpu_stall_q <= 1'b0;
            state_q <= ST_READ;
          end else begin
            hold_cnt_q <= hold_cnt_q + 4'h1;
          end
        end
        ST_READ: begin
          nv_rd_q <= 1'b1;
          nv_addr_q <= item_addr(item_q);
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (nv_rd_valid) begin
            // each item loaded in turn; security byte last
            case (item_q)
              `FSRC_ITEM_CONFIG: block_config_q <= nv_rd_data[7:0];
              `FSRC_ITEM_PPROT: program_area_protection_register_q <= nv_rd_data[7:0];
              `FSRC_ITEM_DPROT: data_area_protection_register_q <= nv_rd_data[7:0];
              `FSRC_ITEM_OPTION: option_register_q <= nv_rd_data[7:0];
              default: security_register_q <= nv_rd_data[7:0];
            endcase
            if (item_q == `FSRC_ITEM_LAST) begin
              state_q <= ST_IDLE;
            end else begin
              item_q <= item_q + 3'h1;
              state_q <= ST_READ;
            end
          end
        end
        ST_IDLE: begin
          if (item_q == `FSRC_ITEM_LAST) begin
            // end of reset sequence: apply defaults on any fault
            item_q <= 3'h0;
            if (seq_any_error || nv_rd_error || nv_double_fault) begin
              security_register_q <= `FSRC_DFLT_SECURITY;
              program_area_protection_register_q <= `FSRC_DFLT_PROT;
              data_area_protection_register_q <= `FSRC_DFLT_PROT;
              option_register_q <= `FSRC_DFLT_OPTION;
              block_config_q <= `FSRC_DFLT_CONFIG;
              security_state_field_q <= 1'b1;
            end else begin
              security_state_field_q <= !is_unsecure(security_register_q);
            end
            if (seq_double_fault || nv_double_fault) begin
              verify_status_bits_q <= 2'h3;
            end
            command_complete_flag_q <= 1'b1;
            cmdreg_wr_en_q <= 1'b1;
            debug_enabled_q <= is_unsecure(security_register_q) && !seq_any_error;
          end else if (cmd_launch) begin
            // availability depends on mode and security state
            if ((security_state_field_q ? cmd_allowed_secure : cmd_allowed_unsecure)
                && !(cmd_is_verify_key && (key_blocked_q
                || security_register_q[`FSRC_BACKDOOR_KEY_ENABLE_FIELD_MSB:`FSRC_BACKDOOR_KEY_ENABLE_FIELD_LSB]
                   != BACKDOOR_KEY_ENABLE_FIELD_ENABLED))) begin
              cmd_accepted_q <= 1'b1;
              command_complete_flag_q <= 1'b0;
              cmdreg_wr_en_q <= 1'b0;
              verify_status_bits_q <= 2'h0;
              if (cmd_is_verify_key) begin
                key_cmd_q <= 1'b1;
                key_bad_q <= 1'b0;
                flash_read_invalid_q <= 1'b1;
                state_q <= ST_KEY;
              end else begin
                erase_verify_q <= cmd_is_erase_verify_all && special_mode;
                engine_start_q <= 1'b1;
                state_q <= ST_BUSY;
              end
            end else begin
              cmd_rejected_q <= 1'b1;
            end
          end
        end
        ST_BUSY: begin
          if (engine_done) begin
            if (erase_verify_q && engine_erased) begin
              security_state_field_q <= 1'b0;
              security_register_q <= sec_work;
              debug_enabled_q <= 1'b1;
            end
            erase_verify_q <= 1'b0;
            command_complete_flag_q <= 1'b1;
            cmdreg_wr_en_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_KEY: begin
          // read the four stored words; nothing nonvolatile is written
          if (!nv_rd_q && !nv_rd_valid && hold_cnt_q != 4'hF) begin
            nv_rd_q <= 1'b1;
            nv_addr_q <= `FSRC_ADDR_KEY_BASE + {14'h0, item_q[1:0], 2'h0} - {15'h0, item_q} * 18'h2;
            hold_cnt_q <= 4'hF;
          end else if (nv_rd_valid) begin
            hold_cnt_q <= 4'h0;
            if (!key_ok[item_q[1:0]] || key_illegal[item_q[1:0]]) begin
              key_bad_q <= 1'b1;
            end
            if (item_q == `FSRC_NUM_KEYS - 3'h1) begin
              item_q <= 3'h0;
              key_cmd_q <= 1'b0;
              flash_read_invalid_q <= 1'b0;
              command_complete_flag_q <= 1'b1;
              cmdreg_wr_en_q <= 1'b1;
              state_q <= ST_IDLE;
              if (key_bad_q || !key_ok[item_q[1:0]]) begin
                key_blocked_q <= 1'b1;
                verify_status_bits_q <= 2'h2;
              end else begin
                security_register_q <= sec_work;
                security_state_field_q <= 1'b0;
                debug_enabled_q <= 1'b1;
              end
            end else begin
              item_q <= item_q + 3'h1;
            end
          end
        end
        default: state_q <= ST_HOLD;
      endcase
    end
  end
endmodule // fsrc_ctrl

/* File: fsrc_defines.vh */
// constants for the flash security and reset-sequence control block
`ifndef FSRC_DEFINES_VH
`define FSRC_DEFINES_VH
// nonvolatile configuration field addresses (18-bit global)
`define FSRC_ADDR_SEC_BYTE 18'h3FF0F
`define FSRC_ADDR_KEY_BASE 18'h3FF00
`define FSRC_ADDR_KEY_LAST 18'h3FF07
`define FSRC_NUM_KEYS 3'h4
// security byte field positions
`define FSRC_SEC_LSB 0
`define FSRC_SEC_MSB 1
`define FSRC_BACKDOOR_KEY_ENABLE_FIELD_LSB 6
`define FSRC_BACKDOOR_KEY_ENABLE_FIELD_MSB 7
`define FSRC_SEC_UNSECURE 2'h2
`define FSRC_SEC_SECURE 2'h3
// built-in fully protected and secured defaults
`define FSRC_DFLT_SECURITY 8'hFF
`define FSRC_DFLT_PROT 8'h00
`define FSRC_DFLT_OPTION 8'hFF
`define FSRC_DFLT_CONFIG 8'h00
// forbidden key words
`define FSRC_KEY_ZERO 16'h0000
`define FSRC_KEY_ONES 16'hFFFF
// reset sequence item indices
`define FSRC_ITEM_CONFIG 3'h0
`define FSRC_ITEM_PPROT 3'h1
`define FSRC_ITEM_DPROT 3'h2
`define FSRC_ITEM_OPTION 3'h3
`define FSRC_ITEM_SEC 3'h4
`define FSRC_ITEM_LAST 3'h4
// cycles of the initial hold in the reset sequence
`define FSRC_HOLD_CYCLES 4'h8
`endif

/* File: fsrc_key_check.v */
// backdoor key comparator: one stored word against one candidate
`timescale 1ns/1ns
module fsrc_key_check #(
  parameter WIDTH = 16
) (
  // operands
  input wire [WIDTH-1:0] stored_word,
  input wire [WIDTH-1:0] candidate_word,
  // result
  output wire word_ok,
  output wire word_illegal
);
  // all-zeros and all-ones can never unlock, even if stored that way
  assign word_illegal = (stored_word == {WIDTH{1'b0}}) || (stored_word == {WIDTH{1'b1}});
  assign word_ok = (stored_word == candidate_word) && !word_illegal;
endmodule // fsrc_key_check

/* File: fsrc_ecc_status.v */
// sticky collection of read faults seen during the reset sequence
`timescale 1ns/1ns
module fsrc_ecc_status (
  // clock and reset
  input wire clk,
  input wire resetn,
  input wire clk_en,
  // fault inputs
  input wire clear,
  input wire read_strobe,
  input wire read_error,
  input wire double_fault,
  // sticky results
  output reg any_error_q,
  output reg double_fault_q
);
  // a fault in the same cycle as clear is kept: set wins
  always @(posedge clk) begin
    if (!resetn) begin
      any_error_q <= 1'b0;
      double_fault_q <= 1'b0;
    end else if (clk_en) begin
      any_error_q <= (any_error_q & ~clear) | (read_strobe & (read_error | double_fault));
      double_fault_q <= (double_fault_q & ~clear) | (read_strobe & double_fault);
    end
  end
endmodule // fsrc_ecc_status

/* File: fsrc_ctrl_sva.sv */
// assertion checker for the flash security and reset-sequence control
`timescale 1ns/1ns
module fsrc_ctrl_chk #(
  parameter [1:0] BACKDOOR_KEY_ENABLE_FIELD_ENABLED = 2'h2,
  parameter [3:0] HOLD_CYCLES = 4'h8
) (
  // watched ports
  input wire clk,
  input wire resetn,
  input wire nv_rd_q,
  input wire [17:0] nv_addr_q,
  input wire cmd_launch,
  input wire cmd_is_verify_key,
  input wire stop_req,
  input wire [7:0] security_register_q,
  input wire [7:0] program_area_protection_register_q,
  input wire command_complete_flag_q,
  input wire cpu_stall_q,
  input wire flash_read_invalid_q,
  input wire cmd_accepted_q,
  input wire cmd_rejected_q,
  input wire cmdreg_wr_en_q,
  input wire key_blocked_q,
  input wire stop_ack_q,
  input wire engine_start_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // key check: accepted with reads blocked, then done with reads back
  sequence s_key_go; cmd_accepted_q && flash_read_invalid_q; endsequence
  sequence s_key_end; ##[1:400] command_complete_flag_q && !flash_read_invalid_q; endsequence
  property p_hold; $rose(resetn) |-> cpu_stall_q [*8]; endproperty
  property p_seq_low; nv_rd_q |-> !command_complete_flag_q; endproperty
  property p_wr_gate; !command_complete_flag_q |-> !cmdreg_wr_en_q; endproperty
  property p_addr; nv_rd_q |-> nv_addr_q[17:4] == 14'h3FF0; endproperty
  property p_answer;
    cmd_accepted_q || cmd_rejected_q |-> $past(cmd_launch) && !(cmd_accepted_q && cmd_rejected_q);
  endproperty
  property p_key; s_key_go |-> s_key_end; endproperty
  property p_block_stick; key_blocked_q |=> key_blocked_q; endproperty
  property p_block_rej;
    cmd_launch && command_complete_flag_q && cmd_is_verify_key && key_blocked_q |=> cmd_rejected_q;
  endproperty
  // outside a command nothing may touch security or protection
  property p_stable;
    $past(command_complete_flag_q) |->
      $stable(security_register_q) && $stable(program_area_protection_register_q);
  endproperty
  property p_stop; stop_req && !command_complete_flag_q |=> !stop_ack_q; endproperty
  // the engine only starts with an accepted command that is not a key check
  property p_start; engine_start_q |-> cmd_accepted_q && !flash_read_invalid_q; endproperty
  a_hold: assert property (p_hold) else $error("stall dropped early");
  a_seq_low: assert property (p_seq_low) else $error("complete high while reading");
  a_wr_gate: assert property (p_wr_gate) else $error("command writes open early");
  a_addr: assert property (p_addr) else $error("read outside config field");
  a_answer: assert property (p_answer) else $error("bad launch answer");
  a_key: assert property (p_key) else $error("key check did not end");
  a_block_stick: assert property (p_block_stick) else $error("lockout lost");
  a_block_rej: assert property (p_block_rej) else $error("blocked key not refused");
  a_stable: assert property (p_stable) else $error("security changed when idle");
  a_stop: assert property (p_stop) else $error("stop granted while busy");
  a_start: assert property (p_start) else $error("engine started without accept");
endmodule // fsrc_ctrl_chk
bind fsrc_ctrl fsrc_ctrl_chk #(.BACKDOOR_KEY_ENABLE_FIELD_ENABLED(BACKDOOR_KEY_ENABLE_FIELD_ENABLED), .HOLD_CYCLES(HOLD_CYCLES)) chk_inst (.*);

/* File: fsrc_nv_model.sv */
// nonvolatile configuration field model answering reset and key reads
`timescale 1ns/1ns
module fsrc_nv_model (
  // read request
  input wire clk,
  input wire nv_rd_q,
  input wire [17:0] nv_addr_q,
  // bench controls: slow answers, injected faults
  input wire slow,
  input wire inj_err,
  input wire inj_dbl,
  // read answer
  output reg nv_rd_valid,
  output reg [15:0] nv_rd_data,
  output reg nv_rd_error,
  output reg nv_double_fault
);
  reg [15:0] mem [0:15];
  reg [3:0] a_q;
  reg [3:0] wait_q;
  reg busy_q;
  // keys at words 0, 2, 4, 6, config bytes 8..11, security byte 15, byte in both halves
  initial begin
    mem[0] = 16'h1234;
    mem[2] = 16'h5678;
    mem[4] = 16'h9ABC;
    mem[6] = 16'hDEF0;
    mem[8] = 16'hA1A1;
    mem[9] = 16'hB2B2;
    mem[10] = 16'hC3C3;
    mem[11] = 16'hD4D4;
    mem[15] = 16'hBFBF;
    busy_q = 1'h0;
    wait_q = 4'h0;
    a_q = 4'h0;
    nv_rd_valid = 1'h0;
    nv_rd_data = 16'hA5A5;
    nv_rd_error = 1'h0;
    nv_double_fault = 1'h0;
  end
  // one answer per request; data toggles when idle so stale values never pass
  always @(posedge clk) begin
    nv_rd_valid <= 1'h0;
    nv_rd_error <= 1'h0;
    nv_double_fault <= 1'h0;
    nv_rd_data <= ~nv_rd_data;
    if (nv_rd_q) begin
      busy_q <= 1'h1;
      a_q <= nv_addr_q[3:0];
      wait_q <= slow ? 4'h5 : 4'h0;
    end else if (busy_q && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end else if (busy_q) begin
      busy_q <= 1'h0;
      nv_rd_valid <= 1'h1;
      nv_rd_data <= mem[a_q];
      nv_rd_error <= inj_err;
      nv_double_fault <= inj_dbl;
    end
  end
endmodule // fsrc_nv_model

/* File: fsrc_tb.sv */
// self-checking bench for the flash security and reset-sequence control
`timescale 1ns/1ns
module tb;
  reg clk, resetn, clk_en, special_mode, cmd_launch, cmd_is_verify_key, cmd_is_erase_verify_all;
  reg cmd_allowed_secure, cmd_allowed_unsecure, engine_done, engine_erased, cmdreg_wr, stop_req;
  reg slow, inj_err, inj_dbl, acc, st;
  reg [63:0] cmd_keys;
  wire nv_rd_q, nv_rd_valid, nv_rd_error, nv_double_fault, security_state_field_q;
  wire command_complete_flag_q, cpu_stall_q, flash_read_invalid_q, cmd_accepted_q;
  wire cmd_rejected_q, cmdreg_wr_en_q, debug_enabled_q, key_blocked_q, stop_ack_q, engine_start_q;
  wire [17:0] nv_addr_q;
  wire [15:0] nv_rd_data;
  wire [7:0] security_register_q, program_area_protection_register_q;
  wire [7:0] data_area_protection_register_q, option_register_q, block_config_q;
  wire [1:0] verify_status_bits_q;
  integer fails, checked, i;
  localparam [63:0] GOOD = 64'hDEF09ABC56781234;
  fsrc_ctrl fsrc_ctrl_inst (.*);
  fsrc_nv_model fsrc_nv_model_inst (.*);
  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input [7:0] s, input [7:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("mismatch at %0t seen %0h expected %0h", $time, s, e);
      end
    end
  endtask
  task results;
    begin
      if (fails == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // bounded wait: a hang ends the run as a failure
  task wait_done;
    integer n;
    begin
      n = 0;
      while (command_complete_flag_q !== 1'h1 && n < 400) begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 400) begin
        fails = fails + 1;
        results;
      end
    end
  endtask
  task rst;
    begin
      @(negedge clk);
      resetn = 1'h0;
      repeat (4) @(negedge clk);
      chk(command_complete_flag_q, 8'h00);
      chk(cpu_stall_q, 8'h01);
      resetn = 1'h1;
      repeat (2) @(negedge clk);
      chk(cmdreg_wr_en_q, 8'h00);
      wait_done;
      chk(cpu_stall_q, 8'h00);
    end
  endtask
  task boot(input [7:0] b);
    begin
      fsrc_nv_model_inst.mem[15] = {b, b};
      rst;
    end
  endtask
  // one command at a time; the answer pulse is caught in either of two cycles
  task launch(input vk, input ev, input [63:0] k);
    begin
      wait_done;
      @(negedge clk);
      cmd_is_verify_key = vk;
      cmd_is_erase_verify_all = ev;
      cmd_keys = k;
      cmd_launch = 1'h1;
      @(negedge clk);
      cmd_launch = 1'h0;
      acc = 1'h0;
      st = 1'h0;
      repeat (2) begin
        if (cmd_accepted_q === 1'h1) acc = 1'h1;
        if (engine_start_q === 1'h1) st = 1'h1;
        @(negedge clk);
      end
    end
  endtask
  task finish_cmd;
    begin
      engine_done = 1'h1;
      @(negedge clk);
      engine_done = 1'h0;
      wait_done;
      @(negedge clk);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fails = 0;
    checked = 0;
    {resetn, special_mode, cmd_launch, cmd_is_verify_key, cmd_is_erase_verify_all} = 5'h00;
    {engine_done, engine_erased, cmdreg_wr, stop_req, slow, inj_err, inj_dbl} = 7'h00;
    {clk_en, cmd_allowed_secure, cmd_allowed_unsecure} = 3'h7;
    cmd_keys = 64'h0;
    boot(8'hBF);
    chk(security_register_q, 8'hBF);
    chk(security_state_field_q, 8'h01);
    chk(block_config_q, 8'hA1);
    chk(program_area_protection_register_q, 8'hB2);
    chk(data_area_protection_register_q, 8'hC3);
    chk(option_register_q, 8'hD4);
    chk(cmdreg_wr_en_q, 8'h01);
    // wrong key locks out; a reprogrammed byte waits for reset
    fsrc_nv_model_inst.mem[15] = 16'h7E7E;
    launch(1'h1, 1'h0, GOOD ^ 64'h1);
    wait_done;
    chk(acc, 8'h01);
    chk(st, 8'h00);
    chk(key_blocked_q, 8'h01);
    chk(verify_status_bits_q, 8'h02);
    chk(security_register_q, 8'hBF);
    launch(1'h1, 1'h0, GOOD);
    chk(acc, 8'h00);
    chk(security_state_field_q, 8'h01);
    rst;
    chk(security_register_q, 8'h7E);
    chk(security_state_field_q, 8'h00);
    chk(key_blocked_q, 8'h00);
    // unsecured availability input decides when unsecured
    cmd_allowed_unsecure = 1'h0;
    launch(1'h0, 1'h0, GOOD);
    chk(acc, 8'h00);
    cmd_allowed_unsecure = 1'h1;
    // slow memory, correct key unlocks
    slow = 1'h1;
    boot(8'hBF);
    launch(1'h1, 1'h0, GOOD);
    chk(flash_read_invalid_q, 8'h01);
    chk(command_complete_flag_q, 8'h00);
    wait_done;
    chk(security_register_q, 8'hBE);
    chk(security_state_field_q, 8'h00);
    chk(program_area_protection_register_q, 8'hB2);
    chk(flash_read_invalid_q, 8'h00);
    slow = 1'h0;
    // forbidden stored words never unlock even when presented; a disabled key-enable field refuses verify-key
    for (i = 0; i < 2; i = i + 1) begin
      fsrc_nv_model_inst.mem[0] = i ? 16'hFFFF : 16'h0000;
      boot(8'hBF);
      launch(1'h1, 1'h0, {GOOD[63:16], fsrc_nv_model_inst.mem[0]});
      wait_done;
      chk(security_state_field_q, 8'h01);
    end
    fsrc_nv_model_inst.mem[0] = 16'h1234;
    boot(8'h7F);
    launch(1'h1, 1'h0, GOOD);
    chk(acc, 8'h00);
    // availability, busy flag, stop handshake, reset abort
    cmd_allowed_secure = 1'h0;
    launch(1'h0, 1'h0, GOOD);
    chk(acc, 8'h00);
    chk(st, 8'h00);
    cmd_allowed_secure = 1'h1;
    stop_req = 1'h1;
    launch(1'h0, 1'h0, GOOD);
    chk(acc, 8'h01);
    chk(st, 8'h01);
    chk(command_complete_flag_q, 8'h00);
    chk(stop_ack_q, 8'h00);
    // frozen clock enable: an engine done pulse is not taken
    clk_en = 1'h0;
    engine_done = 1'h1;
    repeat (3) @(negedge clk);
    engine_done = 1'h0;
    clk_en = 1'h1;
    @(negedge clk);
    chk(command_complete_flag_q, 8'h00);
    chk(stop_ack_q, 8'h00);
    finish_cmd;
    chk(stop_ack_q, 8'h01);
    stop_req = 1'h0;
    launch(1'h0, 1'h0, GOOD);
    rst;
    chk(command_complete_flag_q, 8'h01);
    // erased verify outside special mode leaves the part secured
    engine_erased = 1'h1;
    launch(1'h0, 1'h1, GOOD);
    finish_cmd;
    chk(security_state_field_q, 8'h01);
    chk(debug_enabled_q, 8'h00);
    // debug-port path: special mode, erase-verify finds all erased
    special_mode = 1'h1;
    boot(8'hBF);
    launch(1'h0, 1'h1, GOOD);
    finish_cmd;
    chk(security_state_field_q, 8'h00);
    chk(security_register_q, 8'hBE);
    chk(debug_enabled_q, 8'h01);
    {special_mode, engine_erased} = 2'h0;
    // faults during the reset sequence
    inj_err = 1'h1;
    boot(8'hBF);
    chk(security_register_q, 8'hFF);
    chk(program_area_protection_register_q, 8'h00);
    chk(option_register_q, 8'hFF);
    inj_err = 1'h0;
    inj_dbl = 1'h1;
    boot(8'hBF);
    chk(verify_status_bits_q, 8'h03);
    inj_dbl = 1'h0;
    results;
  end
endmodule // tb
